// file: design/gio_pkg.sv
// Package: register map, field layout and carriers for the port block
package gio_pkg;

  localparam int unsigned GIO_PORTS = 4;
  localparam int unsigned GIO_W = 8;

  // Port indices
  localparam logic [1:0] GIO_PA = 2'h0;
  localparam logic [1:0] GIO_PB = 2'h1;
  localparam logic [1:0] GIO_PC = 2'h2;
  localparam logic [1:0] GIO_PD = 2'h3;

  // Register offsets within the control register block
  localparam logic [7:0] GIO_OFF_A_LEVEL = 8'h04;
  localparam logic [7:0] GIO_OFF_B_LEVEL = 8'h05;
  localparam logic [7:0] GIO_OFF_A_DIR = 8'h06;
  localparam logic [7:0] GIO_OFF_B_DIR = 8'h07;
  localparam logic [7:0] GIO_OFF_A_DRIVE = 8'h08;
  localparam logic [7:0] GIO_OFF_A_OE_STAT = 8'h0c;
  localparam logic [7:0] GIO_OFF_B_OE_STAT = 8'h0d;
  localparam logic [7:0] GIO_OFF_C_LEVEL = 8'h12;
  localparam logic [7:0] GIO_OFF_D_LEVEL = 8'h13;
  localparam logic [7:0] GIO_OFF_C_DIR = 8'h14;
  localparam logic [7:0] GIO_OFF_C_OE_STAT = 8'h1a;
  localparam logic [7:0] GIO_OFF_D_OE_STAT = 8'h1b;

  // Implemented bit masks per port
  localparam logic [7:0] GIO_MASK_A = 8'hff;
  localparam logic [7:0] GIO_MASK_B = 8'hff;
  localparam logic [7:0] GIO_MASK_C = 8'h9c;
  localparam logic [7:0] GIO_MASK_D = 8'h06;

  // Drive select field layout
  localparam int unsigned GIO_OD_LSB = 4;
  localparam int unsigned GIO_SLEW_LSB = 0;
  localparam int unsigned GIO_FLD_W = 4;

  // Reset values
  localparam logic [7:0] GIO_RST_LEVEL = 8'h00;
  localparam logic [7:0] GIO_RST_DIR = 8'h00;
  localparam logic [7:0] GIO_RST_DRIVE = 8'h00;
  localparam logic [7:0] GIO_RD_NONE = 8'h00;

  typedef enum logic [1:0] {
    GIO_K_NONE = 2'h0,
    GIO_K_LEVEL = 2'h1,
    GIO_K_DIR = 2'h3,
    GIO_K_STAT = 2'h2
  } gio_kind_t;

  typedef struct packed {
    logic hit;
    logic drive;
    gio_kind_t kind;
    logic [1:0] port;
  } gio_dec_t;

  // Processor register access, one cycle per strobe
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gio_bus_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gio_pins_t;

endpackage

// file: design/gio_pin_drv.sv
// Module: one port's output-enable selection and pin driver
`timescale 1ns/1ps
module gio_pin_drv import gio_pkg::*; (
  // Register state
  input wire logic [7:0] level,
  input wire logic [7:0] dir,
  input wire logic [7:0] mask,
  input wire logic [7:0] od,
  // Logic-array source
  input wire logic [7:0] pt_sel,
  input wire logic [7:0] pt_oe,
  // Peripheral source
  input wire logic [7:0] per_sel,
  input wire logic [7:0] per_oe,
  input wire logic [7:0] per_out,
  // Pin and status
  output gio_pins_t pins,
  output logic [7:0] final_oe
);

  logic [7:0] data;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // Peripheral mode wins, then product term, else direction
      if (per_sel[i]) begin
        final_oe[i] = per_oe[i] & mask[i];
        data[i] = per_out[i];
      end else if (pt_sel[i]) begin
        final_oe[i] = pt_oe[i] & mask[i];
        data[i] = level[i];
      end else begin
        final_oe[i] = dir[i] & mask[i];
        data[i] = level[i];
      end
    end
  end

  // Open drain only ever pulls low; driver off when enable is low
  assign pins.oe = final_oe & ~(od & data);
  assign pins.out = data & ~od & pins.oe;

endmodule

// file: design/gio_port_regs.sv
// Module: processor I/O mode port registers for ports A to D
`timescale 1ns/1ps

module gio_port_regs import gio_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register access from the processor bus
  input gio_bus_t bus,
  output logic [7:0] rd_data_q,
  // Logic-array output enables, per port
  input wire logic [3:0][7:0] pt_sel,
  input wire logic [3:0][7:0] pt_oe,
  // Peripheral I/O mode, port A only
  input wire logic [7:0] per_sel_a,
  input wire logic [7:0] per_oe_a,
  input wire logic [7:0] per_out_a,
  // Port pins
  output gio_pins_t [3:0] pins,
  output logic [3:0] slew_limit_a
);

  logic [7:0] level_q [GIO_PORTS];
  logic [7:0] dir_q [GIO_PORTS];
  logic [7:0] drive_q;
  logic [3:0][7:0] final_oe;
  logic [3:0][7:0] port_mask;
  gio_dec_t wdec;
  gio_dec_t rdec;
  // Qualified strobes
  logic bus_wr;
  logic bus_rd;
  logic wr_drive;
  logic [3:0] wr_level;
  logic [3:0] wr_dir;
  // One-hot read selects and their masked terms
  logic [3:0] rd_level;
  logic [3:0] rd_dir;
  logic [3:0] rd_stat;
  logic [3:0][7:0] rd_term;
  logic [7:0] rd_value;

  // Decode of an offset, used for both write and read paths
  function automatic gio_dec_t decode(input logic [7:0] addr);
    gio_dec_t d;
    d = '{hit: 1'b1, drive: 1'b0, kind: GIO_K_NONE, port: GIO_PA};
    case (addr)
      GIO_OFF_A_LEVEL: begin
        d.kind = GIO_K_LEVEL;
        d.port = GIO_PA;
      end
      GIO_OFF_B_LEVEL: begin
        d.kind = GIO_K_LEVEL;
        d.port = GIO_PB;
      end
      GIO_OFF_C_LEVEL: begin
        d.kind = GIO_K_LEVEL;
        d.port = GIO_PC;
      end
      GIO_OFF_D_LEVEL: begin
        d.kind = GIO_K_LEVEL;
        d.port = GIO_PD;
      end
      GIO_OFF_A_DIR: begin
        d.kind = GIO_K_DIR;
        d.port = GIO_PA;
      end
      GIO_OFF_B_DIR: begin
        d.kind = GIO_K_DIR;
        d.port = GIO_PB;
      end
      GIO_OFF_C_DIR: begin
        d.kind = GIO_K_DIR;
        d.port = GIO_PC;
      end
      GIO_OFF_A_OE_STAT: begin
        d.kind = GIO_K_STAT;
        d.port = GIO_PA;
      end
      GIO_OFF_B_OE_STAT: begin
        d.kind = GIO_K_STAT;
        d.port = GIO_PB;
      end
      GIO_OFF_C_OE_STAT: begin
        d.kind = GIO_K_STAT;
        d.port = GIO_PC;
      end
      GIO_OFF_D_OE_STAT: begin
        d.kind = GIO_K_STAT;
        d.port = GIO_PD;
      end
      GIO_OFF_A_DRIVE: begin
        d.drive = 1'b1;
      end
      default: begin
        d.hit = 1'b0;
      end
    endcase
    return d;
  endfunction

  // Implemented bits of one port; the rest never hold a one
  function automatic logic [7:0] impl_bits(input logic [1:0] p);
    logic [7:0] m;
    case (p)
      GIO_PA: m = GIO_MASK_A;
      GIO_PB: m = GIO_MASK_B;
      GIO_PC: m = GIO_MASK_C;
      GIO_PD: m = GIO_MASK_D;
      default: m = GIO_RD_NONE;
    endcase
    return m;
  endfunction

  // True when a decoded offset names one register of one port
  function automatic logic targets(input gio_dec_t d, input gio_kind_t k,
    input logic [1:0] p);
    return d.hit && !d.drive && (d.kind == k) && (d.port == p);
  endfunction

  // Decode happens once the processor has placed the offset
  // in its data space
  assign wdec = decode(bus.addr);
  assign rdec = decode(bus.addr);

  // Strobes qualified by the block select
  assign bus_wr = bus.sel & bus.wr;
  assign bus_rd = bus.sel & bus.rd;
  // Status offsets decode but never reach a store
  assign wr_drive = bus_wr & wdec.hit & wdec.drive;

  // One flop bank per port and concern
  for (genvar p = 0; p < GIO_PORTS; p++) begin : g_store
    localparam logic [1:0] PIDX = 2'(p);

    assign port_mask[p] = impl_bits(PIDX);
    assign wr_level[p] = bus_wr & targets(wdec, GIO_K_LEVEL, PIDX);
    assign wr_dir[p] = bus_wr & targets(wdec, GIO_K_DIR, PIDX);
    assign rd_level[p] = targets(rdec, GIO_K_LEVEL, PIDX);
    assign rd_dir[p] = targets(rdec, GIO_K_DIR, PIDX);
    assign rd_stat[p] = targets(rdec, GIO_K_STAT, PIDX);

    // Output level
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        level_q[p] <= GIO_RST_LEVEL;
      end else if (wr_level[p]) begin
        // Masked store keeps missing bits at zero
        level_q[p] <= bus.wdata & port_mask[p];
      end
    end

    // Direction, one selects output
    // Port D has no offset, so its bank stays at reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        dir_q[p] <= GIO_RST_DIR;
      end else if (wr_dir[p]) begin
        dir_q[p] <= bus.wdata & port_mask[p];
      end
    end

    // One-hot selects, so the read mux is a plain OR of terms
    assign rd_term[p] = ({8{rd_level[p]}} & level_q[p]) |
      ({8{rd_dir[p]}} & dir_q[p]) |
      ({8{rd_stat[p]}} & final_oe[p]);
  end

  // Port A drive type
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= GIO_RST_DRIVE;
    end else if (wr_drive) begin
      drive_q <= bus.wdata;
    end
  end

  // Read mux; unmapped offsets select no term and read zero
  always_comb begin
    rd_value = GIO_RD_NONE;
    if (rdec.drive) begin
      rd_value = drive_q;
    end
    for (int p = 0; p < GIO_PORTS; p++) begin
      rd_value = rd_value | rd_term[p];
    end
  end

  // Registered read data, held until the next read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= GIO_RD_NONE;
    end else if (bus_rd) begin
      rd_data_q <= rd_value;
    end
  end

  // Slew limit is a pad setting only; no logic effect here
  assign slew_limit_a = drive_q[GIO_SLEW_LSB +: GIO_FLD_W];

  // One driver per port; peripheral and open drain reach port A only
  for (genvar p = 0; p < GIO_PORTS; p++) begin : g_port
    logic [7:0] od;
    logic [7:0] per_sel;
    logic [7:0] per_oe;
    logic [7:0] per_out;
    if (p == 0) begin : g_a
      assign od = {drive_q[GIO_OD_LSB +: GIO_FLD_W], 4'h0};
      assign per_sel = per_sel_a;
      assign per_oe = per_oe_a;
      assign per_out = per_out_a;
    end else begin : g_bcd
      assign od = 8'h00;
      assign per_sel = 8'h00;
      assign per_oe = 8'h00;
      assign per_out = 8'h00;
    end
    gio_pin_drv u_drv (
      .level(level_q[p]),
      .dir(dir_q[p]),
      .mask(port_mask[p]),
      .od(od),
      .pt_sel(pt_sel[p]),
      .pt_oe(pt_oe[p]),
      .per_sel(per_sel),
      .per_oe(per_oe),
      .per_out(per_out),
      .pins(pins[p]),
      .final_oe(final_oe[p])
    );
  end

endmodule

// file: sim/gio_pad_model.sv
// Partner: pads with pull-ups on the port pins
`timescale 1ns/1ps
module gio_pad_model import gio_pkg::*; (
  // Pin drivers
  input gio_pins_t [3:0] pins,
  // Pad levels
  output logic [3:0][7:0] pad
);
  // Released pads go to the pull-up, never the last driven value
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pad[p] = (pins[p].out & pins[p].oe) | ~pins[p].oe;
    end
  end
endmodule

// file: sim/gio_port_regs_assertions.sv
// Checker: bus and pin relations of the port block
`timescale 1ns/1ps
module gio_chk import gio_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bus
  input gio_bus_t bus,
  input wire logic [7:0] rd_data_q,
  // Enable sources
  input wire logic [3:0][7:0] pt_sel,
  input wire logic [3:0][7:0] pt_oe,
  input wire logic [7:0] per_sel_a,
  input wire logic [7:0] per_oe_a,
  input wire logic [7:0] per_out_a,
  // Pins
  input gio_pins_t [3:0] pins,
  input wire logic [3:0] slew_limit_a
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_b_level: assert property (
    bus.sel && bus.wr && bus.addr == 8'h05 ##1 pt_sel[1] == 8'h00
    |-> pins[1].out == ($past(bus.wdata) & pins[1].oe))
    else $error("B level");
  chk_b_dir: assert property (
    bus.sel && bus.wr && bus.addr == 8'h07 ##1 pt_sel[1] == 8'h00
    |-> pins[1].oe == $past(bus.wdata)) else $error("B dir");
  chk_stat_read: assert property (
    bus.sel && bus.rd && !bus.wr && bus.addr == 8'h0d
    |=> rd_data_q == $past(pins[1].oe)) else $error("B status");
  chk_unmapped_read: assert property (
    bus.sel && bus.rd && bus.addr == 8'h30 |=> rd_data_q == 8'h00)
    else $error("unmapped");
  chk_c_mask: assert property ((pins[2].oe & 8'h63) == 8'h00)
    else $error("C mask");
  chk_slew_map: assert property (
    bus.sel && bus.wr && bus.addr == 8'h08
    |=> slew_limit_a == $past(bus.wdata[3:0])) else $error("slew");
  chk_per_prio: assert property (
    per_sel_a[0] |-> pins[0].oe[0] == per_oe_a[0]) else $error("per");
  chk_pt_src: assert property (
    pt_sel[3][1] |-> pins[3].oe[1] == pt_oe[3][1]) else $error("pt");
endmodule

bind gio_port_regs gio_chk chk_u (.ref_clk, .rst_b, .bus, .rd_data_q,
  .pt_sel, .pt_oe, .per_sel_a, .per_oe_a, .per_out_a, .pins,
  .slew_limit_a);

// file: sim/gio_port_regs_bench.sv
// Testbench: register access and pin checks for the port block
`timescale 1ns/1ps
module gio_port_regs_bench import gio_pkg::*;;
  logic ref_clk, rst_b;
  gio_bus_t bus;
  logic [7:0] rd_data_q, v, per_sel_a, per_oe_a, per_out_a;
  logic [3:0][7:0] pt_sel, pt_oe, pad;
  gio_pins_t [3:0] pins;
  logic [3:0] slew_limit_a;
  int fail_count = 0, tests_run = 0;
  logic [7:0] offs [7] = '{8'h05, 8'h07, 8'h08, 8'h12, 8'h13, 8'h14, 8'h06};
  logic [7:0] msk [7] = '{8'hff, 8'hff, 8'hff, 8'h9c, 8'h06, 8'h9c, 8'hff};

  gio_port_regs dut_u (.ref_clk, .rst_b, .bus, .rd_data_q, .pt_sel,
    .pt_oe, .per_sel_a, .per_oe_a, .per_out_a, .pins, .slew_limit_a);
  gio_pad_model pad_u (.pins, .pad);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Held one edge; a following call makes the next access back to back
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b1, 1'b0, a, d};
  endtask
  task automatic idle();
    @(posedge ref_clk);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
    idle();
    v = rd_data_q;
  endtask
  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #20us;
    fail_count++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    bus = '0;
    pt_sel = '0;
    pt_oe = '0;
    per_sel_a = 8'h00;
    per_oe_a = 8'h00;
    per_out_a = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk(v, 8'h00);
    end
    chk(pins[1].oe | pins[2].oe, 8'h00);
    $display("test reset done");
    foreach (offs[i]) begin
      wr(offs[i], 8'hff);
      rd(offs[i]);
      chk(v, msk[i]);
    end
    chk({4'h0, slew_limit_a}, 8'h0f);
    $display("test masks done");
    wr(8'h05, 8'ha5);
    wr(8'h07, 8'h3c);
    idle();
    chk(pins[1].oe, 8'h3c);
    chk(pad[1], 8'he7);
    chk(pins[2].out & pins[2].oe, 8'h9c);
    wr(8'h0d, 8'h00);
    rd(8'h30);
    chk(v, 8'h00);
    rd(8'h0d);
    chk(v, 8'h3c);
    $display("test port b done");
    @(posedge ref_clk);
    pt_sel[3] <= 8'hff;
    pt_oe[3] <= 8'hff;
    rd(8'h1b);
    chk(v, 8'h06);
    chk(pins[3].out, 8'h06);
    // Open drain on A7..A4: a one releases the pad
    wr(8'h04, 8'h30);
    idle();
    chk(pins[0].oe, 8'hcf);
    chk(pad[0], 8'h30);
    @(posedge ref_clk);
    per_sel_a <= 8'h01;
    per_oe_a <= 8'h01;
    per_out_a <= 8'h01;
    pt_sel[0] <= 8'h02;
    rd(8'h0c);
    chk(v, 8'hfd);
    chk(pad[0], 8'h33);
    @(posedge ref_clk);
    per_oe_a <= 8'h00;
    rd(8'h0c);
    chk(v, 8'hfc);
    $display("test sources done");
    test_done();
  end
endmodule
